// File: nbl_chain_model.sv
// Far side model: host reference, analog lock and chain neighbour
`timescale 1ns/1ns
module nbl_chain_model (
  input  wire logic hclk,
  input  wire logic sync_run,
  input  wire logic pll_good,
  input  wire logic answer,
  input  wire logic send_disc_frames,
  output logic      sync_pin,
  output logic      resp_frame_pin,
  output logic      pll_locked_pin
);
  logic [5:0] div = 6'h00;

  // Free divider paces the reference and the answers
  always_ff @(posedge hclk) begin
    div <= div + 6'h01;
  end

  // steady frame-rate reference
  // Stands low when stopped, as a broken cable would leave it
  assign sync_pin = sync_run & div[2];
  // answers only while discovery frames flow
  // Two clocks wide so the pin synchronizer cannot miss it
  assign resp_frame_pin = answer & send_disc_frames & (div[5:1] == 5'h00);
  // Analog lock needs a live reference
  assign pll_locked_pin = pll_good & sync_run;
endmodule

// File: nbl_lock_counter.sv
// Lock window counter: counts reference ticks of one lock attempt
`timescale 1ns/1ns
module nbl_lock_counter #(
  parameter int WINDOW = 360
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic run,
  input  wire logic tick,
  output logic      done
);

  logic [9:0] count;

  // Restarts whenever run drops; done pulses at the end of each window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 10'h000;
      done  <= 1'b0;
    end else if (!run) begin
      count <= 10'h000;
      done  <= 1'b0;
    end else if (tick) begin
      if (count == 10'(WINDOW - 1)) begin
        count <= 10'h000;
        done  <= 1'b1;
      end else begin
        count <= count + 10'h001;
        done  <= 1'b0;
      end
    end else begin
      done <= 1'b0;
    end
  end

endmodule

// File: nbl_node_bringup.sv
// Node bring-up sequencer with AHB-Lite register slave
`timescale 1ns/1ns
module nbl_node_bringup (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Reference and chain pins
  input  wire logic        sync_pin,
  input  wire logic        ctrl_frame_pin,
  input  wire logic        resp_frame_pin,
  input  wire logic        line_fault_pin,
  input  wire logic        pll_locked_pin,
  output logic             pll_lock_start,
  output logic             pll_ref_is_sync,
  output logic             send_ctrl_frames,
  output logic             send_disc_frames,
  output logic             switch_closed,
  output logic             send_resp_frames,
  // Interrupt pin, two signals, and the main lock flag
  output logic             irq_o,
  output logic             irq_oe,
  output logic             main_locked
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [4:0] pin_prev;
  logic       sync_rise;
  logic       frame_rise;
  logic       resp_rise;

  // Two flops per pin; edges taken from the second stage only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
      pin_prev <= 5'h00;
    end else begin
      pin_meta <= {pll_locked_pin, line_fault_pin, resp_frame_pin,
                   ctrl_frame_pin, sync_pin};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign sync_rise  = pin_sync[0] & ~pin_prev[0];
  assign frame_rise = pin_sync[1] & ~pin_prev[1];
  assign resp_rise  = pin_sync[2] & ~pin_prev[2];

  // ************************************************************
  // Register bus
  // ************************************************************
  nbl_pkg::nbl_bus_req_s req;
  logic [7:0]            node_control_reg;
  logic [7:0]            pin_config_reg;
  logic [7:0]            switch_control_reg;
  logic [7:0]            response_cycle_target;
  logic [7:0]            interrupt_type_code;
  nbl_pkg::nbl_state_e   state;
  logic                  wr_en;
  logic                  rd_irq;
  logic                  ever_locked;
  logic                  soft_reset_request;
  logic                  main_role_select;

  // Address phase capture; one wait-free cycle per transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req <= '0;
    end else if (hready) begin
      req.valid <= hsel & htrans[1];
      req.write <= hwrite;
      req.addr  <= haddr[7:0];
    end
  end

  assign wr_en  = req.valid & req.write;
  assign rd_irq = hsel & htrans[1] & ~hwrite & hready
                  & (haddr[7:0] == nbl_pkg::ADDR_IRQ_TYPE);

  // Always ready, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read mux registered from the address phase
  function automatic logic [31:0] read_word(input logic [7:0] a,
      input logic [7:0] ctl, input logic [7:0] pin,
      input logic [7:0] sw, input logic [7:0] rc,
      input logic [7:0] it, input logic [3:0] st);
    case (a)
      nbl_pkg::ADDR_NODE_CONTROL: read_word = {24'h00_0000, ctl};
      nbl_pkg::ADDR_PIN_CONFIG:   read_word = {24'h00_0000, pin};
      nbl_pkg::ADDR_SWITCH_CTRL:  read_word = {24'h00_0000, sw};
      nbl_pkg::ADDR_RESP_CYCLE:   read_word = {24'h00_0000, rc};
      nbl_pkg::ADDR_IRQ_TYPE:     read_word = {24'h00_0000, it};
      nbl_pkg::ADDR_STATUS:       read_word = {28'h000_0000, st};
      default:                    read_word = 32'h0000_0000;
    endcase
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel & htrans[1] & ~hwrite & hready) begin
      hrdata <= read_word(haddr[7:0], node_control_reg, pin_config_reg,
                          switch_control_reg, response_cycle_target,
                          interrupt_type_code,
                          {ever_locked, main_locked, 2'(state)});
    end
  end

  // ************************************************************
  // Control register
  // ************************************************************
  assign soft_reset_request = wr_en
      & (req.addr == nbl_pkg::ADDR_NODE_CONTROL)
      & hwdata[nbl_pkg::CTL_SOFT_RESET];
  assign main_role_select = node_control_reg[nbl_pkg::CTL_MAIN_ROLE];

  // Control survives soft reset; switch and response-cycle registers do not
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      node_control_reg <= nbl_pkg::CONTROL_RESET;
    end else begin
      node_control_reg[nbl_pkg::CTL_SOFT_RESET] <= 1'b0; // Self clearing
      node_control_reg[nbl_pkg::CTL_DISC_ABORT] <= 1'b0;
      if (wr_en && req.addr == nbl_pkg::ADDR_NODE_CONTROL) begin
        node_control_reg[nbl_pkg::CTL_SOFT_RESET] <=
            hwdata[nbl_pkg::CTL_SOFT_RESET];
        node_control_reg[nbl_pkg::CTL_DISC_ABORT] <=
            hwdata[nbl_pkg::CTL_DISC_ABORT];
        node_control_reg[6:2] <= hwdata[6:2];
        if (state != nbl_pkg::NBL_LOCKED) begin
          node_control_reg[nbl_pkg::CTL_MAIN_ROLE] <=
              hwdata[nbl_pkg::CTL_MAIN_ROLE];
        end
      end
    end
  end

  // Pin, switch, response-cycle registers; soft reset clears switch and response-cycle only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_config_reg        <= nbl_pkg::PINCFG_RESET;
      switch_control_reg    <= 8'h00;
      response_cycle_target <= 8'h00;
    end else if (soft_reset_request) begin
      switch_control_reg    <= 8'h00;
      response_cycle_target <= 8'h00;
    end else if (wr_en) begin
      if (req.addr == nbl_pkg::ADDR_PIN_CONFIG) begin
        pin_config_reg <= hwdata[7:0];
      end
      if (req.addr == nbl_pkg::ADDR_SWITCH_CTRL) begin
        switch_control_reg <= hwdata[7:0];
      end
      if (req.addr == nbl_pkg::ADDR_RESP_CYCLE) begin
        response_cycle_target <= hwdata[7:0];
      end
    end
  end

  // ************************************************************
  // Lock sequencer
  // ************************************************************
  logic ref_tick;
  logic ref_present;
  logic window_done;
  logic [5:0] miss_count;
  logic [9:0] gap_count;
  logic lock_lost;

  // main role uses SYNC, subordinate uses frames
  assign ref_tick = main_role_select ? sync_rise : frame_rise;

  nbl_lock_counter #(
    .WINDOW (nbl_pkg::LOCK_WINDOW_CYCLES)
  ) u_window (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (state == nbl_pkg::NBL_LOCKING),
    .tick    (ref_tick),
    .done    (window_done)
  );

  // Reference seen recently; a gap of idle ticks marks it absent
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_count   <= 10'h000;
      ref_present <= 1'b0;
    end else if (ref_tick) begin
      gap_count   <= 10'h000;
      ref_present <= 1'b1;
    end else if (gap_count == 10'h3FF) begin
      // Wraps so each silent span counts as one miss
      ref_present <= 1'b0;
      gap_count   <= 10'h000;
    end else begin
      gap_count <= gap_count + 10'h001;
    end
  end

  // Missed frames: each 1024-clock span with no frame counts as one miss
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      miss_count <= 6'h00;
    end else if (state != nbl_pkg::NBL_LOCKED || ref_tick) begin
      miss_count <= 6'h00;
    end else if (gap_count == 10'h3FF
                 && miss_count != 6'(nbl_pkg::MISSED_FRAME_LIMIT)) begin
      miss_count <= miss_count + 6'h01;
    end
  end

  // drop lock after 32 misses; main loses SYNC
  assign lock_lost = main_role_select ? ~ref_present
      : (miss_count == 6'(nbl_pkg::MISSED_FRAME_LIMIT));

  // State machine over reset, power-up, locking and locked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= nbl_pkg::NBL_RESET;
    end else begin
      case (state)
        nbl_pkg::NBL_RESET: begin
          state <= nbl_pkg::NBL_POWER_UP;
        end
        nbl_pkg::NBL_POWER_UP: begin
          if (ref_present && (main_role_select || !soft_reset_request)) begin
            state <= nbl_pkg::NBL_LOCKING;
          end
        end
        nbl_pkg::NBL_LOCKING: begin
          // full window, then test, else retry
          if (soft_reset_request || !ref_present) begin
            state <= nbl_pkg::NBL_POWER_UP;
          end else if (window_done && pin_sync[4]) begin
            state <= nbl_pkg::NBL_LOCKED;
          end
        end
        nbl_pkg::NBL_LOCKED: begin
          if (lock_lost || soft_reset_request) begin
            state <= nbl_pkg::NBL_POWER_UP;
          end
        end
        default: state <= nbl_pkg::NBL_RESET;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_lock_start  <= 1'b0;
      pll_ref_is_sync <= 1'b0;
    end else begin
      pll_lock_start <= (state == nbl_pkg::NBL_POWER_UP && ref_present)
          || (state == nbl_pkg::NBL_LOCKING && window_done
              && !pin_sync[4]);
      pll_ref_is_sync <= main_role_select;
    end
  end

  // ************************************************************
  // Discovery
  // ************************************************************
  logic locked_now;
  logic disc_active;
  logic resp_seen;

  assign locked_now = (state == nbl_pkg::NBL_LOCKED);

  // switch closes only with a clean line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      switch_closed    <= 1'b0;
      send_ctrl_frames <= 1'b0;
    end else begin
      switch_closed <= switch_control_reg[nbl_pkg::SW_ENABLE]
          & locked_now & ~pin_sync[3];
      send_ctrl_frames <= switch_control_reg[nbl_pkg::SW_ENABLE]
          & locked_now & ~pin_sync[3];
    end
  end

  // discovery runs from target write until answer or abort
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disc_active <= 1'b0;
      resp_seen   <= 1'b0;
    end else if (!locked_now || soft_reset_request
                 || node_control_reg[nbl_pkg::CTL_DISC_ABORT]) begin
      disc_active <= 1'b0;
      resp_seen   <= 1'b0;
    end else if (wr_en && req.addr == nbl_pkg::ADDR_RESP_CYCLE
                 && main_role_select) begin
      disc_active <= 1'b1;
      resp_seen   <= 1'b0;
    end else if (disc_active && resp_rise) begin
      resp_seen <= 1'b1;
    end
  end

  // subordinate answers once locked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      send_disc_frames <= 1'b0;
      send_resp_frames <= 1'b0;
    end else begin
      send_disc_frames <= disc_active & ~resp_seen;
      send_resp_frames <= locked_now & ~main_role_select;
    end
  end

  // ************************************************************
  // Interrupt
  // ************************************************************
  logic irq_active;
  logic lock_event;
  logic disc_event;
  logic fault_event;

  assign lock_event  = (state == nbl_pkg::NBL_LOCKING) && window_done
                       && pin_sync[4] && main_role_select;
  assign disc_event  = disc_active && resp_rise && !resp_seen;
  assign fault_event = switch_control_reg[nbl_pkg::SW_ENABLE]
                       && pin_sync[3] && locked_now && !switch_closed
                       && interrupt_type_code == nbl_pkg::IRQ_TYPE_NONE;

  // code held until read; set wins over read clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_type_code <= nbl_pkg::IRQ_TYPE_NONE;
    end else if (lock_event) begin
      interrupt_type_code <= nbl_pkg::IRQ_MAIN_LOCKED;
    end else if (disc_event) begin
      interrupt_type_code <= nbl_pkg::IRQ_DISCOVERED;
    end else if (fault_event) begin
      interrupt_type_code <= nbl_pkg::IRQ_LINE_FAULT;
    end else if (rd_irq) begin
      interrupt_type_code <= nbl_pkg::IRQ_TYPE_NONE;
    end
  end

  assign irq_active = (interrupt_type_code != nbl_pkg::IRQ_TYPE_NONE);

  // pin released until the first lock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ever_locked <= 1'b0;
      main_locked <= 1'b0;
      irq_o       <= 1'b0;
      irq_oe      <= 1'b0;
    end else begin
      if (locked_now) begin
        ever_locked <= 1'b1;
      end
      main_locked <= locked_now & main_role_select;
      irq_o  <= irq_active ^ pin_config_reg[nbl_pkg::PIN_IRQ_INVERT];
      irq_oe <= ever_locked
          & ~(pin_config_reg[nbl_pkg::PIN_IRQ_TRISTATE] & ~irq_active);
    end
  end

endmodule

// File: nbl_node_bringup_test.sv
// Self-checking bench for the node bring-up sequencer
`timescale 1ns/1ns
module nbl_node_bringup_test;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0]  htrans;
  logic        sync_run, pll_good, answer, line_fault_pin, frames;
  logic        sync_pin, resp_frame_pin, pll_locked_pin, pll_lock_start;
  logic        pll_ref_is_sync, send_ctrl_frames, send_disc_frames;
  logic        switch_closed, send_resp_frames, irq_o, irq_oe, main_locked;
  int          fail_count = 0;
  int          tests_run = 0;

  // 20 MHz bus clock
  always #25 hclk = ~hclk;

  nbl_node_bringup uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sync_pin(sync_pin), .ctrl_frame_pin(frames & sync_pin),
    .resp_frame_pin(resp_frame_pin), .line_fault_pin(line_fault_pin),
    .pll_locked_pin(pll_locked_pin), .pll_lock_start(pll_lock_start),
    .pll_ref_is_sync(pll_ref_is_sync), .send_ctrl_frames(send_ctrl_frames),
    .send_disc_frames(send_disc_frames), .switch_closed(switch_closed),
    .send_resp_frames(send_resp_frames), .irq_o(irq_o), .irq_oe(irq_oe),
    .main_locked(main_locked)
  );

  nbl_chain_model far (
    .hclk(hclk), .sync_run(sync_run), .pll_good(pll_good), .answer(answer),
    .send_disc_frames(send_disc_frames), .sync_pin(sync_pin),
    .resp_frame_pin(resp_frame_pin), .pll_locked_pin(pll_locked_pin)
  );

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic pchk(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Bounded wait for hready; a hung slave ends the run
  task automatic hold_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      $display("mismatch hready expected 1 seen %b", hreadyout);
      final_report();
    end
  endtask

  // One single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    hold_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    hold_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h00_0000, d}, rdv);
  endtask

  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [7:0] exp);
    bus(1'b0, a, 32'h0000_0000, rdv);
    chk(what, {24'h00_0000, exp}, rdv);
  endtask

  // Waits on ref, lock, irq pin, switch, discovery frames, answers
  task automatic wait_on(input int sel, input logic v, input int lim);
    logic [5:0] s;
    for (int n = 0; n < lim; n++) begin
      s = {send_resp_frames, send_disc_frames, switch_closed, irq_o,
           main_locked, pll_ref_is_sync};
      if (s[sel] === v) return;
      @(posedge hclk);
    end
    fail_count++;
    $display("mismatch wait_%0d expected %b seen %b", sel, v, s[sel]);
    final_report();
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    sync_run = 1'b1;
    pll_good = 1'b0;
    answer = 1'b0;
    line_fault_pin = 1'b0;
    frames = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // Reference present, role not requested: no locking
    rchk("control", nbl_pkg::ADDR_NODE_CONTROL, 8'h00);
    rchk("pin_config", nbl_pkg::ADDR_PIN_CONFIG, 8'h00);
    rchk("irq_code", nbl_pkg::ADDR_IRQ_TYPE, 8'h00);
    rchk("unmapped", 8'h20, 8'h00);
    rchk("status", nbl_pkg::ADDR_STATUS, 8'h01);
    pchk("irq_oe", 1'b0, irq_oe);
    pchk("ref_sync", 1'b0, pll_ref_is_sync);
    pchk("hresp", 1'b0, hresp);
    $display("test reset image done");
    // Failed attempts retry, then lock
    wr(nbl_pkg::ADDR_NODE_CONTROL, 8'h80);
    wait_on(0, 1'b1, 16);
    repeat (6500) @(posedge hclk);
    pchk("locked_early", 1'b0, main_locked);
    rchk("status", nbl_pkg::ADDR_STATUS, 8'h02);
    pll_good <= 1'b1;
    wait_on(1, 1'b1, 4000);
    rchk("status", nbl_pkg::ADDR_STATUS, 8'h0F);
    pchk("irq_oe", 1'b1, irq_oe);
    pchk("irq_high", 1'b1, irq_o);
    pchk("resp_frames", 1'b0, send_resp_frames);
    rchk("irq_code", nbl_pkg::ADDR_IRQ_TYPE, 8'hFF);
    wait_on(2, 1'b0, 8);
    rchk("irq_code", nbl_pkg::ADDR_IRQ_TYPE, 8'h00);
    $display("test main lock done");
    // Role writes ignored while locked
    wr(nbl_pkg::ADDR_NODE_CONTROL, 8'h00);
    rchk("control", nbl_pkg::ADDR_NODE_CONTROL, 8'h80);
    pchk("still_locked", 1'b1, main_locked);
    // Reference break and resume
    sync_run <= 1'b0;
    wait_on(1, 1'b0, 1500);
    rchk("control", nbl_pkg::ADDR_NODE_CONTROL, 8'h80);
    rchk("status", nbl_pkg::ADDR_STATUS, 8'h09);
    sync_run <= 1'b1;
    wait_on(1, 1'b1, 4000);
    rchk("irq_code", nbl_pkg::ADDR_IRQ_TYPE, 8'hFF);
    $display("test relock done");
    // Discovery of the next node
    wr(nbl_pkg::ADDR_SWITCH_CTRL, 8'h01);
    wait_on(3, 1'b1, 32);
    pchk("ctrl_frames", 1'b1, send_ctrl_frames);
    wr(nbl_pkg::ADDR_RESP_CYCLE, 8'h5A);
    wait_on(4, 1'b1, 16);
    rchk("resp_cycle", nbl_pkg::ADDR_RESP_CYCLE, 8'h5A);
    answer <= 1'b1;
    wait_on(2, 1'b1, 400);
    rchk("irq_code", nbl_pkg::ADDR_IRQ_TYPE, 8'h18);
    repeat (200) @(posedge hclk);
    rchk("irq_again", nbl_pkg::ADDR_IRQ_TYPE, 8'h00);
    answer <= 1'b0;
    $display("test discovery done");
    // Reset pin mid-run, then active-low interrupt sequence
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    pchk("irq_oe", 1'b0, irq_oe);
    hresetn <= 1'b1;
    rchk("irq_code", nbl_pkg::ADDR_IRQ_TYPE, 8'h00);
    wr(nbl_pkg::ADDR_NODE_CONTROL, 8'h01);
    wr(nbl_pkg::ADDR_PIN_CONFIG, 8'h01);
    wr(nbl_pkg::ADDR_NODE_CONTROL, 8'h80);
    wait_on(1, 1'b1, 4000);
    rchk("pin_config", nbl_pkg::ADDR_PIN_CONFIG, 8'h01);
    pchk("irq_low", 1'b0, irq_o);
    rchk("irq_code", nbl_pkg::ADDR_IRQ_TYPE, 8'hFF);
    wait_on(2, 1'b1, 8);
    $display("test invert done");
    // Faulty line keeps the switch open
    line_fault_pin <= 1'b1;
    wr(nbl_pkg::ADDR_SWITCH_CTRL, 8'h01);
    wait_on(2, 1'b0, 32);
    rchk("irq_code", nbl_pkg::ADDR_IRQ_TYPE, 8'h29);
    pchk("switch", 1'b0, switch_closed);
    wr(nbl_pkg::ADDR_NODE_CONTROL, 8'h82);
    pchk("disc_frames", 1'b0, send_disc_frames);
    $display("test fault done");
    // Subordinate role locks to control frames and answers
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    frames <= 1'b1;
    wait_on(5, 1'b1, 4000);
    pchk("sub_main", 1'b0, main_locked);
    rchk("status", nbl_pkg::ADDR_STATUS, 8'h0B);
    $display("test subordinate done");
    final_report();
  end
endmodule

// File: nbl_pkg.sv
// Package of constants and types for the node bring-up sequencer
package nbl_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] ADDR_NODE_CONTROL  = 8'h00;
  localparam logic [7:0] ADDR_PIN_CONFIG    = 8'h04;
  localparam logic [7:0] ADDR_SWITCH_CTRL   = 8'h08;
  localparam logic [7:0] ADDR_RESP_CYCLE    = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_TYPE      = 8'h10;
  localparam logic [7:0] ADDR_STATUS        = 8'h14;

  // Field positions
  localparam int CTL_SOFT_RESET   = 0;
  localparam int CTL_DISC_ABORT   = 1;
  localparam int CTL_MAIN_ROLE    = 7;
  localparam int PIN_IRQ_INVERT   = 0;
  localparam int PIN_IRQ_TRISTATE = 1;
  localparam int SW_ENABLE        = 0;

  // Reset values
  localparam logic [7:0] CONTROL_RESET  = 8'h00;
  localparam logic [7:0] PINCFG_RESET   = 8'h00;
  localparam logic [7:0] IRQ_TYPE_NONE  = 8'h00;

  // Interrupt type codes
  localparam logic [7:0] IRQ_MAIN_LOCKED = 8'hFF;
  localparam logic [7:0] IRQ_DISCOVERED  = 8'h18;
  localparam logic [7:0] IRQ_LINE_FAULT  = 8'h29;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int LOCK_WINDOW_CYCLES = 360;
  localparam int MISSED_FRAME_LIMIT = 32;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    NBL_RESET,
    NBL_POWER_UP,
    NBL_LOCKING,
    NBL_LOCKED
  } nbl_state_e;

  // Bus address phase captured for the data phase
  typedef struct packed {
    logic       write;
    logic       valid;
    logic [7:0] addr;
  } nbl_bus_req_s;

  // Link side events from the chain
  typedef struct packed {
    logic ctrl_frame;
    logic resp_frame;
    logic line_fault;
  } nbl_link_s;

endpackage

// File: nbl_props.sv
// Concurrent checks on the node bring-up sequencer pins
`timescale 1ns/1ns
module nbl_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sync_pin,
  input wire logic line_fault_pin,
  input wire logic pll_lock_start,
  input wire logic pll_ref_is_sync,
  input wire logic send_ctrl_frames,
  input wire logic switch_closed,
  input wire logic irq_oe,
  input wire logic send_resp_frames,
  input wire logic main_locked
);
  logic        sync_q;
  logic        armed;
  logic        ever;
  logic [8:0]  edges;
  logic [10:0] gap;

  // Raw reference edges per attempt; the pin delay cancels out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_q <= 1'b0;
      edges  <= 9'h000;
      gap    <= 11'h000;
    end else begin
      sync_q <= sync_pin;
      if (pll_lock_start) begin
        edges <= 9'h000;
      end else if (sync_pin && !sync_q && edges != 9'h1FF) begin
        edges <= edges + 9'h001;
      end
      if (sync_pin && !sync_q) begin
        gap <= 11'h000;
      end else if (gap != 11'h7FF) begin
        gap <= gap + 11'h001;
      end
    end
  end

  // Attempt seen since last lock; any lock seen since reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed <= 1'b0;
      ever  <= 1'b0;
    end else begin
      ever <= ever | main_locked | send_resp_frames;
      if (pll_lock_start) begin
        armed <= 1'b1;
      end else if (main_locked) begin
        armed <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence fault_steady;
    line_fault_pin [*4];
  endsequence
  sequence pin_driven;
    ##[0:3] irq_oe;
  endsequence
  sequence ctrl_started;
    ##[0:2] send_ctrl_frames;
  endsequence

  a_lock_ref: assert property ($rose(main_locked) |-> pll_ref_is_sync)
    else $error("main lock without sync reference");
  a_lock_irq: assert property ($rose(main_locked) |-> pin_driven)
    else $error("interrupt pin not driven after lock");
  a_pin_float: assert property (!ever && !main_locked |-> !irq_oe)
    else $error("interrupt pin driven before first lock");
  a_retry_space: assert property (
    pll_lock_start && armed |-> edges >= 9'd359 && edges <= 9'd361)
    else $error("lock retry not one full window apart");
  a_lock_window: assert property ($rose(main_locked) |-> edges >= 9'd359)
    else $error("lock declared before window end");
  a_sync_loss: assert property (main_locked |-> gap <= 11'd1040)
    else $error("lock kept without reference");
  a_keep_lock: assert property ($fell(main_locked) |-> gap >= 11'd1024)
    else $error("lock dropped while reference runs");
  a_quiet_reset: assert property ($rose(hresetn) |-> !irq_oe)
    else $error("interrupt pin driven out of reset");
  a_ctrl_start: assert property ($rose(switch_closed) |-> ctrl_started)
    else $error("control frames not sent after switch close");
  a_fault_open: assert property (fault_steady |-> !$rose(switch_closed))
    else $error("switch closed on faulty line");
endmodule

bind nbl_node_bringup nbl_props u_props (
  .hclk(hclk), .hresetn(hresetn), .sync_pin(sync_pin),
  .line_fault_pin(line_fault_pin), .pll_lock_start(pll_lock_start),
  .pll_ref_is_sync(pll_ref_is_sync), .send_ctrl_frames(send_ctrl_frames),
  .switch_closed(switch_closed), .irq_oe(irq_oe), .main_locked(main_locked),
  .send_resp_frames(send_resp_frames)
);
